// File: rtl/epsc_consts.svh
`ifndef EPSC_CONSTS_SVH
`define EPSC_CONSTS_SVH

// register indices as printed; byte address is four times the index
`define EPSC_IDX_LINE_STATUS   13'h0001
`define EPSC_IDX_PORT_CONTROL  13'h0002
`define EPSC_IDX_EXT_MODE      13'h0402
`define EPSC_IDX_IRQ_STATUS    13'h0010
`define EPSC_IDX_IRQ_MASK      13'h0011

// reset values
`define EPSC_RST_PORT_CONTROL  8'h00
`define EPSC_RST_EXT_MODE      3'h0
`define EPSC_RST_IRQ_MASK      2'h1

// status register field positions
`define EPSC_ST_BUSY           7
`define EPSC_ST_ACK            6
`define EPSC_ST_PERR           5
`define EPSC_ST_SEL            4
`define EPSC_ST_FAULT          3
`define EPSC_ST_PORT_INTERRUPT_FLAG           2

// control register field positions
`define EPSC_CT_DIR            5
`define EPSC_CT_ACK_INTERRUPT_ENABLE          4
`define EPSC_CT_SELIN          3
`define EPSC_CT_INIT           2
`define EPSC_CT_AUTOFD         1
`define EPSC_CT_STROBE         0
`define EPSC_CT_WMASK          8'h3f

// extended mode register field
`define EPSC_MODE_HI           7
`define EPSC_MODE_LO           5

// interrupt event bit positions
`define EPSC_EV_ACK            0
`define EPSC_EV_FAULT          1

`endif

// File: rtl/epsc_pkg.sv
package epsc_pkg;

    // port mode field values of the extended mode register
    typedef enum logic [2:0] {
        EPSC_MODE_COMPAT   = 3'h0,
        EPSC_MODE_BIDIR    = 3'h1,
        EPSC_MODE_FIFO     = 3'h2,
        EPSC_MODE_ECP      = 3'h3,
        EPSC_MODE_RSVD4    = 3'h4,
        EPSC_MODE_RSVD5    = 3'h5,
        EPSC_MODE_TEST     = 3'h6,
        EPSC_MODE_CONFIG   = 3'h7
    } epsc_mode_t;

    // decoded register selector
    typedef enum logic [2:0] {
        EPSC_SEL_NONE,
        EPSC_SEL_STATUS,
        EPSC_SEL_CONTROL,
        EPSC_SEL_MODE,
        EPSC_SEL_IRQ_ST,
        EPSC_SEL_IRQ_MK
    } epsc_sel_t;

endpackage : epsc_pkg

// File: rtl/epsc_regs.sv
`timescale 1ns/1ns
`include "epsc_consts.svh"
module epsc_regs
    import epsc_pkg::*;
#(
    parameter int ADDR_W = 15                   // byte address width
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   irq_o,
    // peripheral status lines, true line levels
    input  wire logic              busy_i,
    input  wire logic              ack_n_i,
    input  wire logic              paper_error_i,
    input  wire logic              select_i,
    input  wire logic              fault_n_i,
    // peripheral control lines, true line levels
    output logic                   select_in_n_o,
    output logic                   init_n_o,
    output logic                   auto_feed_n_o,
    output logic                   strobe_n_o,
    // parallel data lines, two-way
    input  wire logic [7:0]        parallel_data_lines_i,
    output logic      [7:0]        parallel_data_lines_o,
    output logic                   parallel_data_lines_oe_o,
    // hardware handshake engine side
    input  wire logic [7:0]        hs_data_i,
    input  wire logic              hs_cmd_cycle_i,
    input  wire logic              hs_auto_feed_n_i,
    input  wire logic              hs_strobe_n_i,
    output logic      [7:0]        hs_data_o,
    output logic      [2:0]        hs_mode_o,
    output logic                   hs_reverse_o,
    output logic                   hs_fifo_dir_ok_o
);

    // software state
    logic [7:0]  port_control_reg;              // control register, bits 7:6 stay zero
    logic [7:0]  port_control_next;
    logic [2:0]  mode_reg;                      // extended mode field
    logic [2:0]  mode_next;
    logic [1:0]  irq_status_reg;                // sticky event bits
    logic [1:0]  irq_status_next;
    logic [1:0]  irq_mask_reg;                  // event mask
    logic [1:0]  irq_mask_next;
    logic [31:0] rdata_reg;                     // read data, loaded in setup
    logic [31:0] rdata_next;
    // line history for edge detection
    logic        ack_n_reg;
    logic        fault_n_reg;
    // data line drive and capture
    logic [7:0]  pd_out_reg;
    logic [7:0]  pd_in_reg;

    // map a byte address to a register selector
    function automatic epsc_sel_t epsc_decode(input logic [ADDR_W-1:0] addr);
        logic [12:0] idx;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            return EPSC_SEL_NONE;               // unaligned never maps
        end
        case (idx)
            `EPSC_IDX_LINE_STATUS:  return EPSC_SEL_STATUS;
            `EPSC_IDX_PORT_CONTROL: return EPSC_SEL_CONTROL;
            `EPSC_IDX_EXT_MODE:     return EPSC_SEL_MODE;
            `EPSC_IDX_IRQ_STATUS:   return EPSC_SEL_IRQ_ST;
            `EPSC_IDX_IRQ_MASK:     return EPSC_SEL_IRQ_MK;
            default:                return EPSC_SEL_NONE;
        endcase
    endfunction : epsc_decode

    // bus phase decode
    wire         setup_w   = psel_i & ~penable_i;
    wire         access_w  = psel_i & penable_i;
    wire         wr_w      = access_w & pwrite_i;
    wire         lane0_w   = pstrb_i[0];      // all fields sit in byte lane 0
    epsc_sel_t   rd_sel_w;
    epsc_sel_t   wr_sel_w;
    assign rd_sel_w = epsc_decode(paddr_i);
    assign wr_sel_w = epsc_decode(paddr_i);
    wire         mapped_w  = (wr_sel_w != EPSC_SEL_NONE);

    // mode decode
    wire         mode_ecp_w   = (mode_reg == EPSC_MODE_ECP);
    wire         mode_fifo_w  = (mode_reg == EPSC_MODE_FIFO);
    wire         hw_owns_w    = mode_ecp_w | mode_fifo_w;

    // control fields
    wire         dir_rev_w    = port_control_reg[`EPSC_CT_DIR];
    wire         irq_en_w     = port_control_reg[`EPSC_CT_ACK_INTERRUPT_ENABLE];

    // status register image; bits 1:0 read zero
    wire         port_interrupt_flag_bit_w   = mode_ecp_w ? 1'b1
                                           : ~irq_status_reg[`EPSC_EV_ACK];
    wire [7:0]   line_status_w = {~busy_i,
                                  ack_n_i,
                                  paper_error_i,
                                  select_i,
                                  fault_n_i,
                                  port_interrupt_flag_bit_w,
                                  2'h0};

    // events: falling edges of nAck and nFault
    wire [1:0]   event_w;
    assign event_w[`EPSC_EV_ACK]   = ack_n_reg & ~ack_n_i & irq_en_w;
    assign event_w[`EPSC_EV_FAULT] = fault_n_reg & ~fault_n_i & irq_en_w;

    // write-one-to-clear pattern for the sticky bits
    wire [1:0]   irq_clr_w = (wr_w & lane0_w && wr_sel_w == EPSC_SEL_IRQ_ST)
                             ? pwdata_i[1:0] : 2'h0;

    // sticky bits: a new event beats a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sticky
            assign irq_status_next[g] = event_w[g] | (irq_status_reg[g] & ~irq_clr_w[g]);
        end
    endgenerate

    // control register write, reserved bits forced to zero
    assign port_control_next = (wr_w & lane0_w && wr_sel_w == EPSC_SEL_CONTROL)
                               ? (pwdata_i[7:0] & `EPSC_CT_WMASK)
                               : port_control_reg;

    // mode register write
    assign mode_next = (wr_w & lane0_w && wr_sel_w == EPSC_SEL_MODE)
                       ? pwdata_i[`EPSC_MODE_HI:`EPSC_MODE_LO]
                       : mode_reg;

    // mask register write
    assign irq_mask_next = (wr_w & lane0_w && wr_sel_w == EPSC_SEL_IRQ_MK)
                           ? pwdata_i[1:0]
                           : irq_mask_reg;

    // read mux; status writes fall through to nothing
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (rd_sel_w)
            EPSC_SEL_STATUS:  rdata_next = {24'h00_0000, line_status_w};
            EPSC_SEL_CONTROL: rdata_next = {24'h00_0000, port_control_reg};
            EPSC_SEL_MODE:    rdata_next = {24'h00_0000, mode_reg, 5'h00};
            EPSC_SEL_IRQ_ST:  rdata_next = {30'h0000_0000, irq_status_reg};
            EPSC_SEL_IRQ_MK:  rdata_next = {30'h0000_0000, irq_mask_reg};
            default:          rdata_next = 32'h0000_0000;
        endcase
    end

    // register state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_control_reg <= `EPSC_RST_PORT_CONTROL;
            mode_reg         <= `EPSC_RST_EXT_MODE;
            irq_status_reg   <= 2'h0;
            irq_mask_reg     <= `EPSC_RST_IRQ_MASK;
        end else begin
            port_control_reg <= port_control_next;
            mode_reg         <= mode_next;
            irq_status_reg   <= irq_status_next;
            irq_mask_reg     <= irq_mask_next;
        end
    end

    // read data captured in setup so access phase answers at once
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup_w) begin
            rdata_reg <= rdata_next;
        end
    end

    // line history; reset to negated so no false edge at start
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_n_reg   <= 1'b1;
            fault_n_reg <= 1'b1;
        end else begin
            ack_n_reg   <= ack_n_i;
            fault_n_reg <= fault_n_i;
        end
    end

    // data line registers, both directions
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_out_reg <= 8'h00;
            pd_in_reg  <= 8'h00;
        end else begin
            pd_out_reg <= hs_data_i;
            pd_in_reg  <= parallel_data_lines_i;
        end
    end

    // apb answer: zero wait, error on unmapped address
    assign prdata_o  = rdata_reg;
    assign pready_o  = access_w;
    assign pslverr_o = access_w & ~mapped_w;

    // interrupt level, gated by enable and mask
    assign irq_o = irq_en_w & |(irq_status_reg & irq_mask_reg);

    // control lines
    assign select_in_n_o = ~port_control_reg[`EPSC_CT_SELIN];
    assign init_n_o      = port_control_reg[`EPSC_CT_INIT];

    // autofeed: handshake owns it in fifo mode, address flag in ecp
    assign auto_feed_n_o = mode_ecp_w  ? ~hs_cmd_cycle_i
                         : mode_fifo_w ? hs_auto_feed_n_i
                         : ~port_control_reg[`EPSC_CT_AUTOFD];
    assign strobe_n_o    = hw_owns_w ? hs_strobe_n_i
                         : ~port_control_reg[`EPSC_CT_STROBE];

    // data lines drive only in forward direction
    assign parallel_data_lines_o    = pd_out_reg;
    assign parallel_data_lines_oe_o = ~dir_rev_w;
    assign hs_data_o                = pd_in_reg;
    assign hs_mode_o                = mode_reg;
    assign hs_reverse_o             = dir_rev_w;
    // fifo compatibility mode only moves data forward
    assign hs_fifo_dir_ok_o         = mode_fifo_w & ~dir_rev_w;

endmodule : epsc_regs

// File: test/epsc_regs_sva.sv
`timescale 1ns/1ns
// port-level watcher of the register block
module epsc_regs_sva
    import epsc_pkg::*;
#(
    parameter int ADDR_W = 15  // byte address width
) (
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0]       prdata_o,
    input wire logic              irq_o,
    input wire logic              busy_i,
    input wire logic              ack_n_i,
    input wire logic              paper_error_i,
    input wire logic              select_i,
    input wire logic              fault_n_i,
    input wire logic              select_in_n_o,
    input wire logic              init_n_o,
    input wire logic              auto_feed_n_o,
    input wire logic              strobe_n_o,
    input wire logic              parallel_data_lines_oe_o,
    input wire logic              hs_cmd_cycle_i,
    input wire logic              hs_auto_feed_n_i,
    input wire logic              hs_strobe_n_i,
    input wire logic [2:0]        hs_mode_o,
    input wire logic              hs_reverse_o,
    input wire logic              hs_fifo_dir_ok_o
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // access phases; read data was latched at the setup edge before
    wire rd_acc = psel_i && penable_i && !pwrite_i;
    wire st_rd  = rd_acc && paddr_i == 15'h0004;
    wire ct_rd  = rd_acc && paddr_i == 15'h0008;
    wire wr_acc = psel_i && penable_i && pwrite_i;
    a_stat_lines: assert property (st_rd |-> prdata_o[7:3] ==
        {!$past(busy_i), $past(ack_n_i), $past(paper_error_i), $past(select_i), $past(fault_n_i)})
        else $error("status line bits wrong");
    a_stat_rsvd: assert property (st_rd |-> prdata_o[1:0] == 2'h0 && prdata_o[31:8] == 24'h00_0000)
        else $error("status reserved bits not zero");
    a_port_interrupt_flag_ecp: assert property (st_rd && $past(hs_mode_o) == EPSC_MODE_ECP |-> prdata_o[2])
        else $error("interrupt bit not one in ecp");
    a_ctl_lines: assert property (ct_rd |-> prdata_o[7:6] == 2'h0 &&
        prdata_o[3] == !select_in_n_o && prdata_o[2] == init_n_o) else $error("control lines disagree");
    a_dir_drive: assert property (ct_rd |-> parallel_data_lines_oe_o == !prdata_o[5])
        else $error("data drive disagrees with direction");
    a_ctl_hold: assert property (!wr_acc |=> $stable(select_in_n_o) && $stable(init_n_o))
        else $error("control line moved without write");
    a_strobe_own: assert property (hs_mode_o inside {EPSC_MODE_ECP, EPSC_MODE_FIFO} |->
        strobe_n_o == hs_strobe_n_i) else $error("strobe not owned by handshake");
    a_afd_ecp: assert property (hs_mode_o == EPSC_MODE_ECP |-> auto_feed_n_o == !hs_cmd_cycle_i)
        else $error("autofeed wrong in ecp");
    a_afd_fifo: assert property (hs_mode_o == EPSC_MODE_FIFO |-> auto_feed_n_o == hs_auto_feed_n_i)
        else $error("autofeed not owned by handshake");
    a_fifo_dir: assert property (hs_fifo_dir_ok_o == (hs_mode_o == EPSC_MODE_FIFO && !hs_reverse_o))
        else $error("fifo direction flag wrong");
    c_stat_read: cover property (st_rd);
    c_ecp_mode: cover property (hs_mode_o == EPSC_MODE_ECP);
    c_irq_rise: cover property ($rose(irq_o));
endmodule : epsc_regs_sva
bind epsc_regs epsc_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// File: test/epsc_printer_model.sv
`timescale 1ns/1ns
// far-side printer: busy on each strobe, then a two-cycle ack pulse
module epsc_printer_model (
    input  wire logic  clk_i,
    input  wire logic  strobe_n_i,  // host strobe, active low
    input  wire logic  slow_i,      // stretch busy before the ack
    output logic       busy_o,
    output logic       ack_n_o,
    output logic [7:0] pd_o         // reverse data, used when host lets go
);
    logic [3:0] cnt_reg = 4'h0;  // cycles left in the handshake
    logic       stb_reg = 1'b1;  // strobe seen last cycle
    logic [7:0] pat_reg = 8'h00; // changes every cycle so stale data shows
    // edge detect and countdown
    always @(posedge clk_i) begin
        stb_reg <= strobe_n_i;
        pat_reg <= pat_reg + 8'h1d;
        if (stb_reg && !strobe_n_i) begin
            cnt_reg <= slow_i ? 4'h8 : 4'h3;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    assign busy_o  = cnt_reg != 4'h0;
    assign ack_n_o = !(cnt_reg inside {4'h1, 4'h2});
    assign pd_o    = pat_reg;
endmodule : epsc_printer_model

// File: test/tb_epsc_regs.sv
`timescale 1ns/1ns
module tb_epsc_regs
    import epsc_pkg::*;
;
    logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i, slow, err;
    logic [14:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, d;
    logic [3:0]  pstrb_i = 4'hf;  // whole-word writes only
    logic        pready_o, pslverr_o, irq_o, busy_i, ack_n_i, paper_error_i, select_i, fault_n_i;
    logic        select_in_n_o, init_n_o, auto_feed_n_o, strobe_n_o, parallel_data_lines_oe_o;
    logic        hs_cmd_cycle_i, hs_auto_feed_n_i, hs_strobe_n_i, hs_reverse_o, hs_fifo_dir_ok_o;
    logic [7:0]  parallel_data_lines_o, hs_data_i, hs_data_o, pd_far, lat, snap;
    logic [2:0]  hs_mode_o;
    // wire level: host wins while it drives, else the printer
    wire  [7:0]  parallel_data_lines_i = parallel_data_lines_oe_o ? parallel_data_lines_o : pd_far;
    int          n_mismatch, samples_checked, cyc;
    epsc_regs u_epsc_regs (.*);
    epsc_printer_model u_epsc_printer_model (
        .clk_i      (clk_i),
        .strobe_n_i (strobe_n_o),
        .slow_i     (slow),
        .busy_o     (busy_i),
        .ack_n_o    (ack_n_i),
        .pd_o       (pd_far)
    );
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // expected status byte in ecp mode from the line levels
    function automatic logic [7:0] exp_stat();
        return {~busy_i, ack_n_i, paper_error_i, select_i, fault_n_i, 3'h4};
    endfunction : exp_stat
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; no wait-state count assumed
    task automatic apb(input logic w, input logic [14:0] a, input logic [31:0] v);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge clk_i);
        snap = exp_stat();  // lines as latched at the setup edge
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        {resetn_i, psel_i, penable_i, pwrite_i, slow, hs_cmd_cycle_i, paper_error_i, select_i} = '0;
        {fault_n_i, hs_strobe_n_i, hs_auto_feed_n_i, paddr_i, pwdata_i, hs_data_i} = {3'h7, 55'h0};
        d = $urandom(32'heb63_8060);
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 check({parallel_data_lines_oe_o, select_in_n_o, init_n_o, irq_o}, 4'hc);
        apb(1'b0, 15'h000c, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            d = $urandom();
            apb(1'b1, 15'h0008, d);
            apb(1'b0, 15'h0008, 32'h0);
            check(rd, d & 32'h0000_003f);
            check({parallel_data_lines_oe_o, select_in_n_o, init_n_o}, {~d[5], ~d[3], d[2]});
        end
        apb(1'b1, 15'h0004, $urandom());
        check(err, 1'b0);
        $display("control test done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 15'h1008, {24'h0, m[2:0], 5'h00});
            apb(1'b1, 15'h0008, 32'h0000_0003);
            {hs_cmd_cycle_i, hs_auto_feed_n_i, hs_strobe_n_i, paper_error_i, select_i, fault_n_i} <= 6'($urandom());
            #1 check({strobe_n_o, auto_feed_n_o, hs_fifo_dir_ok_o, hs_mode_o}, {m[1] ? hs_strobe_n_i : 1'b0,
                m == 3 ? !hs_cmd_cycle_i : m == 2 ? hs_auto_feed_n_i : 1'b0, m == 2, m[2:0]});
        end
        repeat (4) begin
            {hs_strobe_n_i, paper_error_i, select_i, fault_n_i} <= 4'($urandom());
            apb(1'b0, 15'h0004, 32'h0);
            check(rd, {24'h0, snap});
        end
        $display("mode test done");
        fault_n_i <= 1'b1;
        slow <= 1'b1;
        // strobe bit low first, so leaving the handshake modes makes no strobe edge
        apb(1'b1, 15'h0008, 32'h0000_0010);
        apb(1'b1, 15'h1008, 32'h0);
        // let a printer handshake still running from the handshake modes die out
        repeat (12) @(posedge clk_i);
        apb(1'b1, 15'h0040, 32'h0000_0003);
        apb(1'b1, 15'h0008, 32'h0000_0011);
        apb(1'b1, 15'h0008, 32'h0000_0010);
        for (int k = 0; k < 20 && irq_o !== 1'b1; k++) @(posedge clk_i);
        check(irq_o, 1'b1);
        apb(1'b0, 15'h0040, 32'h0);
        check(rd, 32'h0000_0001);
        apb(1'b1, 15'h0044, 32'h0);
        #1 check(irq_o, 1'b0);
        apb(1'b1, 15'h0044, 32'h0000_0001);
        apb(1'b1, 15'h0040, 32'h0000_0001);
        slow <= 1'b0;
        apb(1'b1, 15'h0008, 32'h0000_0001);
        apb(1'b1, 15'h0008, 32'h0);
        repeat (20) @(posedge clk_i);
        check(irq_o, 1'b0);
        $display("interrupt test done");
        apb(1'b1, 15'h1008, 32'h0000_0040);
        apb(1'b1, 15'h0008, 32'h0000_0020);
        #1 check({parallel_data_lines_oe_o, hs_fifo_dir_ok_o}, 2'h0);
        lat = parallel_data_lines_i;
        @(posedge clk_i);
        #1 check(hs_data_o, lat);
        apb(1'b1, 15'h0008, 32'h0);
        hs_data_i <= 8'($urandom());
        @(posedge clk_i);
        #1 check({parallel_data_lines_oe_o, parallel_data_lines_o}, {1'b1, hs_data_i});
        $display("data test done");
        print_verdict();
    end
endmodule : tb_epsc_regs
